// ==== bench/dai_top_asserts.sv ====
// Purpose: Port checks for dai_top
// Assumes: CE_IN held high
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module dai_top_asserts (
  input wire logic               CLK_IN,
  input wire logic               RSTN_IN,
  input wire logic               REG_RD_IN,
  input wire logic [31:0]        REG_RDATA_OUT,
  input wire dai_pkg::dai_slot_t OPT_A_RX_IN,
  input wire dai_pkg::dai_slot_t OPT_B_RX_IN,
  input wire dai_pkg::dai_chan_t RX_A_OUT,
  input wire dai_pkg::dai_chan_t RX_B_OUT,
  input wire dai_pkg::dai_chan_t TX_IN,
  input wire dai_pkg::dai_slot_t OPT_A_TX_OUT,
  input wire dai_pkg::dai_chan_t SER_TX_IN,
  input wire dai_pkg::dai_sub_t  COAX_TX_OUT,
  input wire dai_pkg::dai_sub_t  OPT_B_SER_TX_OUT,
  input wire logic               WCLK_LOCK_OUT,
  input wire logic               REF_WORD_OUT
);
  default clocking @(posedge CLK_IN);
  endclocking
  default disable iff (!RSTN_IN);
  sequence s_a_pass;
    ##1 RX_A_OUT.valid && RX_A_OUT.data == $past(OPT_A_RX_IN.data);
  endsequence
  a_rx_a_pass: assert property (OPT_A_RX_IN.valid |-> s_a_pass)
    else $error("optical A word lost");
  a_rx_b_cause: assert property (RX_B_OUT.valid |-> $past(OPT_B_RX_IN.valid)
    && RX_B_OUT.data == $past(OPT_B_RX_IN.data)) else $error("optical B word invented");
  a_tx_a_cause: assert property (OPT_A_TX_OUT.valid |-> $past(TX_IN.valid)
    && OPT_A_TX_OUT.data == $past(TX_IN.data)) else $error("optical A out invented");
  a_coax_pass: assert property (SER_TX_IN.valid |=> COAX_TX_OUT.valid
    && COAX_TX_OUT.data == $past(SER_TX_IN.data)) else $error("coax word lost");
  a_dual_same: assert property (OPT_B_SER_TX_OUT.valid |-> OPT_B_SER_TX_OUT == COAX_TX_OUT)
    else $error("optical and coax differ");
  a_flat_bits: assert property (COAX_TX_OUT.valid |-> !COAX_TX_OUT.vbit && !COAX_TX_OUT.user)
    else $error("validity or user bit set");
  a_slave_locked: assert property (REF_WORD_OUT |-> WCLK_LOCK_OUT)
    else $error("slaved without lock");
  a_rdata_idle: assert property (!$past(REG_RD_IN) |-> REG_RDATA_OUT == 32'h0000_0000)
    else $error("read data outside read slot");
endmodule

// ==== bench/dai_wck_src.sv ====
// Purpose: Word clock source standing in for outside gear
// Assumes: Period in ns from the bench
// Notes:   Line idles low while disabled, as a terminated cable
`timescale 1ns/1ps
module dai_wck_src (
  input  wire logic        en_in,
  input  wire logic [15:0] per_ns_in,
  output logic             wck_out
);
  initial wck_out = 1'b0;
  always begin
    if (en_in) #(per_ns_in / 2.0) wck_out = ~wck_out;
    else begin
      wck_out = 1'b0;
      @(en_in);
    end
  end
endmodule

// ==== bench/test_digital_audio_io_clock_sync.sv ====
// Purpose: Self-checking bench for dai_top
// Assumes: Word clock from dai_wck_src
// Notes:   Optical A results checked through a queue
`timescale 1ns/1ps
module test_digital_audio_io_clock_sync;
  logic               CLK_IN = 1'b0, RSTN_IN = 1'b0, CE_IN = 1'b1, WCK_IN;
  logic               REG_WR_IN = 1'b0, REG_RD_IN = 1'b0, WCK_OUT, WCLK_LOCK_OUT, REF_WORD_OUT;
  logic [3:0]         REG_ADDR_IN = 4'h0;
  logic [31:0]        REG_WDATA_IN = 32'h0000_0000, REG_RDATA_OUT, exp_q[$];
  dai_pkg::dai_slot_t OPT_A_RX_IN = '0, OPT_B_RX_IN = '0, OPT_A_TX_OUT, OPT_B_TX_OUT;
  dai_pkg::dai_sub_t  COAX_RX_IN = '0, OPT_B_SER_RX_IN = '0, COAX_TX_OUT, OPT_B_SER_TX_OUT;
  dai_pkg::dai_chan_t TX_IN = '0, SER_TX_IN = '0, RX_A_OUT, RX_B_OUT, SER_RX_OUT;
  logic               wck_en = 1'b0, dbl = 1'b0;
  logic [15:0]        wck_per = 16'h007D;
  int                 fails = 0, n_compared = 0, cyc = 0, seed = 97284;
  dai_top u_dut (.*);
  dai_wck_src u_src (.en_in(wck_en), .per_ns_in(wck_per), .wck_out(WCK_IN));
  always #5 CLK_IN = ~CLK_IN;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b1;
    REG_ADDR_IN <= a;
    REG_WDATA_IN <= d;
    @(posedge CLK_IN);
    REG_WR_IN <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b1;
    REG_ADDR_IN <= a;
    @(posedge CLK_IN);
    REG_RD_IN <= 1'b0;
    #1 d = REG_RDATA_OUT;
  endtask
  // Both optical links plus playback in one cycle; A result goes to the queue
  task automatic opt(input logic [2:0] s);
    logic [23:0] d;
    logic [3:0]  ca, cb;
    d = 24'($random(seed));
    ca = dbl ? {2'b00, s[2:1]} : {1'b0, s};
    cb = dbl ? {2'b01, s[2:1]} : {1'b1, s};
    exp_q.push_back({1'b1, ca, dbl & s[0], d});
    @(posedge CLK_IN);
    OPT_A_RX_IN <= {1'b1, s, d};
    OPT_B_RX_IN <= {1'b1, s, d};
    TX_IN <= {1'b1, (d[0] ? cb : ca), dbl & s[0], d};
    @(posedge CLK_IN);
    OPT_A_RX_IN.valid <= 1'b0;
    OPT_B_RX_IN.valid <= 1'b0;
    TX_IN.valid <= 1'b0;
    #1 chk(RX_B_OUT, {1'b1, cb, dbl & s[0], d});
    chk(d[0] ? OPT_B_TX_OUT : OPT_A_TX_OUT, {1'b1, s, d});
  endtask
  task automatic per(input int lo, input int hi);
    realtime t0;
    @(posedge WCK_OUT);
    t0 = $realtime;
    @(posedge WCK_OUT);
    chk(($realtime - t0) > lo && ($realtime - t0) < hi, 1);
  endtask
  always @(posedge CLK_IN) begin
    if (RX_A_OUT.valid === 1'b1) chk(RX_A_OUT, exp_q.size() != 0 ? exp_q.pop_front() : 32'hFFFF_FFFF);
  end
  // Run is about 25k cycles; ceiling leaves margin
  always @(posedge CLK_IN) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    logic [31:0] v;
    logic [39:0] hdr;
    logic [23:0] d;
    logic        na;
    logic        cs_e;
    repeat (8) @(posedge CLK_IN);
    RSTN_IN <= 1'b1;
    repeat (3) @(posedge CLK_IN);
    rd(4'h0, v);
    chk(v, 32'h0000_0400);
    rd(4'hC, v);
    chk(v, 32'h0000_0000);
    repeat (24) opt(3'($random(seed)));
    // Serial input from coax, then from optical B; status bits are noise
    for (int m = 0; m < 2; m++) begin
      wr(4'h0, m[0] ? 32'h0000_0404 : 32'h0000_0400);
      repeat (8) begin
        d = 24'($random(seed));
        na = 1'($random(seed));
        @(posedge CLK_IN);
        COAX_RX_IN <= {1'b1, na, d, 4'($random(seed))};
        OPT_B_SER_RX_IN <= {1'b1, na, ~d, 4'($random(seed))};
        OPT_B_RX_IN <= {1'b1, 3'h0, d};
        @(posedge CLK_IN);
        COAX_RX_IN.valid <= 1'b0;
        OPT_B_SER_RX_IN.valid <= 1'b0;
        OPT_B_RX_IN.valid <= 1'b0;
        #1 chk({SER_RX_OUT, RX_B_OUT.valid}, {1'b1, 3'h0, na, 1'b0, (m[0] ? ~d : d), ~m[0]});
      end
    end
    // ****************************************
    // Header per block, both formats with and without emphasis; non-audio flag random
    // ****************************************
    for (int k = 0; k < 4; k++) begin
      na = 1'($random(seed));
      wr(4'h0, 32'h0000_0408 | {24'h00_0000, k[0], k[1], na, 5'h00});
      hdr = k[1] ? {1'b0, 4'h2, 23'h00_0000, 4'h8, 2'b10, 2'b00, k[0], 1'b1, na, 1'b1} :
                   {12'h000, 4'h2, 20'h0_0000, k[0], 1'b1, na, 1'b0};
      for (int f = 0; f < 192; f++) begin
        for (int b = 0; b < 2; b++) begin
          d = 24'($random(seed));
          cs_e = f < 40 && hdr[f];
          @(posedge CLK_IN);
          SER_TX_IN <= {1'b1, 3'h0, b[0], 1'b0, d};
          @(posedge CLK_IN);
          SER_TX_IN.valid <= 1'b0;
          #1 chk({COAX_TX_OUT.data, COAX_TX_OUT.cs, COAX_TX_OUT.blk}, {d, cs_e, f == 0 && b == 0});
          chk(OPT_B_SER_TX_OUT, {1'b1, b[0], d, cs_e, f == 0 && b == 0, 2'b00});
        end
      end
    end
    // Too fast a word clock must not lock
    wr(4'h0, 32'h0000_0403);
    wck_en = 1'b1;
    repeat (3000) @(posedge CLK_IN);
    chk(WCLK_LOCK_OUT, 0);
    wck_per = 16'h28B0;
    repeat (5000) @(posedge CLK_IN);
    #1 chk({WCLK_LOCK_OUT, REF_WORD_OUT}, 2'b11);
    dbl = 1'b1;
    repeat (24) opt(3'($random(seed)));
    per(10300, 10550);
    wr(4'h0, 32'h0000_0503);
    repeat (4000) @(posedge CLK_IN);
    per(20700, 20950);
    wr(4'h0, 32'h0000_0403);
    wck_en = 1'b0;
    repeat (5000) @(posedge CLK_IN);
    rd(4'h4, v);
    chk({v[6:0], REF_WORD_OUT, WCLK_LOCK_OUT}, {7'h48, 2'b00});
    chk(exp_q.size(), 0);
    wrap_up();
  end
endmodule
bind dai_top dai_top_asserts u_chk (.*);

// ==== hw/dai_pkg.sv ====
// Purpose: Shared constants and types for the digital audio I/O and clock sync block
// Assumes: 100 MHz core clock, 24-bit audio words

package dai_pkg;

  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam longint CLK_HZ          = 64'd100000000;
  localparam int     WCK_TIMEOUT_NS  = 40000;
  localparam int     CLK_PERIOD_NS   = 10;
  localparam int     WCK_TIMEOUT_CYC = WCK_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int     WCK_MIN_NS      = 4000;
  localparam int     WCK_MIN_CYC     = (WCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int     CNT_W           = 13;
  localparam int     CS_BLOCK_LEN    = 192;
  localparam int     CS_HDR_LEN      = 40;

  // ****************************************************************
  // Rates
  // ****************************************************************
  typedef enum logic [2:0] {RATE_32, RATE_44, RATE_48, RATE_88, RATE_96, RATE_176, RATE_192} dai_rate_t;
  typedef enum logic [1:0] {SYNC_MASTER, SYNC_SLAVE, SYNC_FALLBACK} dai_sync_t;

  localparam logic [31:0] INC_32  = 32'((64'd32000  << 32) / CLK_HZ);
  localparam logic [31:0] INC_44  = 32'((64'd44100  << 32) / CLK_HZ);
  localparam logic [31:0] INC_48  = 32'((64'd48000  << 32) / CLK_HZ);
  localparam logic [31:0] INC_88  = 32'((64'd88200  << 32) / CLK_HZ);
  localparam logic [31:0] INC_96  = 32'((64'd96000  << 32) / CLK_HZ);
  localparam logic [31:0] INC_176 = 32'((64'd176400 << 32) / CLK_HZ);
  localparam logic [31:0] INC_192 = 32'((64'd192000 << 32) / CLK_HZ);

  // Period thresholds in cycles, midway between adjacent rates
  localparam logic [CNT_W-1:0] MID_32_44   = CNT_W'((CLK_HZ / 32000 + CLK_HZ / 44100) / 2);
  localparam logic [CNT_W-1:0] MID_44_48   = CNT_W'((CLK_HZ / 44100 + CLK_HZ / 48000) / 2);
  localparam logic [CNT_W-1:0] MID_48_88   = CNT_W'((CLK_HZ / 48000 + CLK_HZ / 88200) / 2);
  localparam logic [CNT_W-1:0] MID_88_96   = CNT_W'((CLK_HZ / 88200 + CLK_HZ / 96000) / 2);
  localparam logic [CNT_W-1:0] MID_96_176  = CNT_W'((CLK_HZ / 96000 + CLK_HZ / 176400) / 2);
  localparam logic [CNT_W-1:0] MID_176_192 = CNT_W'((CLK_HZ / 176400 + CLK_HZ / 192000) / 2);
  localparam logic [CNT_W-1:0] WCK_TO_CNT  = CNT_W'(WCK_TIMEOUT_CYC);
  localparam logic [CNT_W-1:0] WCK_MIN_CNT = CNT_W'(WCK_MIN_CYC);

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_PERIOD = 4'h8;
  localparam int CTRL_AUTO      = 0;
  localparam int CTRL_PREF_WORD = 1;
  localparam int CTRL_B_RX_SER  = 2;
  localparam int CTRL_B_TX_SER  = 3;
  localparam int CTRL_NONAUDIO  = 5;
  localparam int CTRL_PRO       = 6;
  localparam int CTRL_EMPH      = 7;
  localparam int CTRL_SINGLE    = 8;
  localparam int CTRL_RATE_LSB  = 9;
  localparam logic [11:0] CTRL_RESET = 12'h0_400;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic        valid;
    logic [2:0]  slot;
    logic [23:0] data;
  } dai_slot_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  chan;
    logic        phase;
    logic [23:0] data;
  } dai_chan_t;

  typedef struct packed {
    logic        valid;
    logic        sub;
    logic [23:0] data;
    logic        cs;
    logic        blk;
    logic        vbit;
    logic        user;
  } dai_sub_t;

endpackage

// ==== hw/dai_top.sv ====
// Purpose: Channel mapping, serial audio header build and word clock sync
// Assumes: Optical and serial receivers deliver decoded words on this clock
// Notes:   Word clock pin is asynchronous and is sampled by the core clock
`timescale 1ns/1ps

module dai_top (
  input  wire logic               CLK_IN,
  input  wire logic               RSTN_IN,
  input  wire logic               CE_IN,
  input  wire logic [3:0]         REG_ADDR_IN,
  input  wire logic [31:0]        REG_WDATA_IN,
  input  wire logic               REG_WR_IN,
  input  wire logic               REG_RD_IN,
  output logic      [31:0]        REG_RDATA_OUT,
  input  wire dai_pkg::dai_slot_t OPT_A_RX_IN,
  input  wire dai_pkg::dai_slot_t OPT_B_RX_IN,
  input  wire dai_pkg::dai_sub_t  COAX_RX_IN,
  input  wire dai_pkg::dai_sub_t  OPT_B_SER_RX_IN,
  output dai_pkg::dai_chan_t      RX_A_OUT,
  output dai_pkg::dai_chan_t      RX_B_OUT,
  output dai_pkg::dai_chan_t      SER_RX_OUT,
  input  wire dai_pkg::dai_chan_t TX_IN,
  input  wire dai_pkg::dai_chan_t SER_TX_IN,
  output dai_pkg::dai_slot_t      OPT_A_TX_OUT,
  output dai_pkg::dai_slot_t      OPT_B_TX_OUT,
  output dai_pkg::dai_sub_t       COAX_TX_OUT,
  output dai_pkg::dai_sub_t       OPT_B_SER_TX_OUT,
  input  wire logic               WCK_IN,
  output logic                    WCK_OUT,
  output logic                    WCLK_LOCK_OUT,
  output logic                    REF_WORD_OUT
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_s1_q;
  logic rst_n;

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else if (CE_IN) begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  logic [11:0]        ctrl_q;
  logic [11:0]        ctrl_d;
  logic [31:0]        rdata_d;
  logic [31:0]        status_w;
  logic               auto_sync;
  logic               pref_word;
  logic               b_rx_ser;
  logic               b_tx_ser;
  logic               nonaudio;
  logic               pro_fmt;
  logic               emph;
  logic               single_out;
  logic [2:0]         rate_raw;
  dai_pkg::dai_rate_t master_rate;

  assign ctrl_d      = REG_WR_IN && REG_ADDR_IN == dai_pkg::REG_CTRL ? REG_WDATA_IN[11:0] : ctrl_q;
  assign auto_sync   = ctrl_q[dai_pkg::CTRL_AUTO];
  assign pref_word   = ctrl_q[dai_pkg::CTRL_PREF_WORD];
  assign b_rx_ser    = ctrl_q[dai_pkg::CTRL_B_RX_SER];
  assign b_tx_ser    = ctrl_q[dai_pkg::CTRL_B_TX_SER];
  assign nonaudio    = ctrl_q[dai_pkg::CTRL_NONAUDIO];
  assign pro_fmt     = ctrl_q[dai_pkg::CTRL_PRO];
  assign emph        = ctrl_q[dai_pkg::CTRL_EMPH];
  assign single_out  = ctrl_q[dai_pkg::CTRL_SINGLE];
  assign rate_raw    = ctrl_q[dai_pkg::CTRL_RATE_LSB +: 3];
  // Code 7 has no rate; fall back to 48 kHz rather than stall the clock
  assign master_rate = rate_raw == 3'h7 ? dai_pkg::RATE_48 : dai_pkg::dai_rate_t'(rate_raw);

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q        <= dai_pkg::CTRL_RESET;
      REG_RDATA_OUT <= 32'h0000_0000;
    end else if (CE_IN) begin
      ctrl_q        <= ctrl_d;
      REG_RDATA_OUT <= rdata_d;
    end
  end

  // ****************************************************************
  // Word clock input measurement
  // ****************************************************************
  logic                     wck_s1_q;
  logic                     wck_s2_q;
  logic                     wck_s3_q;
  logic                     wck_rise;
  logic [dai_pkg::CNT_W-1:0] cnt_q;
  logic [dai_pkg::CNT_W-1:0] cnt_d;
  logic [dai_pkg::CNT_W-1:0] period_q;
  logic [dai_pkg::CNT_W-1:0] period_d;
  logic                     timeout;
  logic                     in_range;
  logic                     wvalid_q;
  logic                     wvalid_d;
  logic                     wlock_q;
  logic                     wlock_d;
  dai_pkg::dai_rate_t       meas_rate;
  dai_pkg::dai_rate_t       meas_q;
  dai_pkg::dai_rate_t       meas_d;

  assign wck_rise = wck_s2_q && !wck_s3_q;
  assign timeout  = cnt_q >= dai_pkg::WCK_TO_CNT;
  assign in_range = cnt_q >= dai_pkg::WCK_MIN_CNT && !timeout;
  assign cnt_d    = wck_rise ? '0 : (timeout ? cnt_q : cnt_q + 1'b1);
  assign period_d = wck_rise ? cnt_q : period_q;

  // Any standard period is classified, so no speed setting is needed
  assign meas_rate = cnt_q > dai_pkg::MID_32_44   ? dai_pkg::RATE_32  :
                     cnt_q > dai_pkg::MID_44_48   ? dai_pkg::RATE_44  :
                     cnt_q > dai_pkg::MID_48_88   ? dai_pkg::RATE_48  :
                     cnt_q > dai_pkg::MID_88_96   ? dai_pkg::RATE_88  :
                     cnt_q > dai_pkg::MID_96_176  ? dai_pkg::RATE_96  :
                     cnt_q > dai_pkg::MID_176_192 ? dai_pkg::RATE_176 : dai_pkg::RATE_192;

  assign wvalid_d = timeout ? 1'b0 : (wck_rise ? in_range : wvalid_q);
  assign meas_d   = wck_rise && in_range ? meas_rate : meas_q;
  // Two matching periods in a row before lock, so one glitch cannot lock
  assign wlock_d  = timeout ? 1'b0 : (wck_rise ? in_range && wvalid_q && meas_rate == meas_q : wlock_q);

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      wck_s1_q <= 1'b0;
      wck_s2_q <= 1'b0;
      wck_s3_q <= 1'b0;
      cnt_q    <= '0;
      period_q <= '0;
      wvalid_q <= 1'b0;
      wlock_q  <= 1'b0;
      meas_q   <= dai_pkg::RATE_48;
    end else if (CE_IN) begin
      wck_s1_q <= WCK_IN;
      wck_s2_q <= wck_s1_q;
      wck_s3_q <= wck_s2_q;
      cnt_q    <= cnt_d;
      period_q <= period_d;
      wvalid_q <= wvalid_d;
      wlock_q  <= wlock_d;
      meas_q   <= meas_d;
    end
  end

  // ****************************************************************
  // Reference selection
  // ****************************************************************
  dai_pkg::dai_sync_t sync_q;
  dai_pkg::dai_sync_t sync_d;
  dai_pkg::dai_rate_t fb_rate_q;
  dai_pkg::dai_rate_t fb_rate_d;
  dai_pkg::dai_rate_t cur_rate;
  logic               use_word;

  assign use_word = pref_word && auto_sync && wlock_q;

  always_comb begin
    sync_d    = sync_q;
    fb_rate_d = fb_rate_q;
    unique case (sync_q)
      dai_pkg::SYNC_MASTER: begin
        if (use_word) begin
          sync_d = dai_pkg::SYNC_SLAVE;
        end
      end
      dai_pkg::SYNC_SLAVE: begin
        if (!pref_word || !auto_sync) begin
          sync_d = dai_pkg::SYNC_MASTER;
        end else if (!wlock_q) begin
          // Hold the last classified rate as the nearest standard rate
          sync_d    = dai_pkg::SYNC_FALLBACK;
          fb_rate_d = meas_q;
        end
      end
      dai_pkg::SYNC_FALLBACK: begin
        if (use_word) begin
          sync_d = dai_pkg::SYNC_SLAVE;
        end else if (!pref_word || !auto_sync) begin
          sync_d = dai_pkg::SYNC_MASTER;
        end
      end
      default: begin
        sync_d = dai_pkg::SYNC_MASTER;
      end
    endcase
  end

  assign cur_rate = sync_q == dai_pkg::SYNC_SLAVE    ? meas_q :
                    sync_q == dai_pkg::SYNC_FALLBACK ? fb_rate_q : master_rate;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sync_q    <= dai_pkg::SYNC_MASTER;
      fb_rate_q <= dai_pkg::RATE_48;
    end else if (CE_IN) begin
      sync_q    <= sync_d;
      fb_rate_q <= fb_rate_d;
    end
  end

  // ****************************************************************
  // Word clock output
  // ****************************************************************
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic [31:0] inc;
  logic        base;
  logic        base_q;
  logic        base_rise;
  logic [1:0]  div_q;
  logic [1:0]  div_d;
  logic        wck_d;
  logic        slave;

  assign slave = sync_q == dai_pkg::SYNC_SLAVE;

  always_comb begin
    unique case (cur_rate)
      dai_pkg::RATE_32:  inc = dai_pkg::INC_32;
      dai_pkg::RATE_44:  inc = dai_pkg::INC_44;
      dai_pkg::RATE_48:  inc = dai_pkg::INC_48;
      dai_pkg::RATE_88:  inc = dai_pkg::INC_88;
      dai_pkg::RATE_96:  inc = dai_pkg::INC_96;
      dai_pkg::RATE_176: inc = dai_pkg::INC_176;
      dai_pkg::RATE_192: inc = dai_pkg::INC_192;
      default:           inc = dai_pkg::INC_48;
    endcase
  end

  // Slave follows the synced input so edges line up; lag to WCK_OUT is three core cycles
  assign acc_d     = acc_q + inc;
  assign base      = slave ? wck_s2_q : acc_q[31];
  assign base_rise = base && !base_q;
  // Dividers step on rising base edges only, keeping the same phase
  assign div_d     = base_rise ? div_q + 2'b01 : div_q;

  always_comb begin
    wck_d = base;
    if (single_out) begin
      unique case (cur_rate)
        dai_pkg::RATE_88, dai_pkg::RATE_96:   wck_d = div_q[0];
        dai_pkg::RATE_176, dai_pkg::RATE_192: wck_d = div_q[1];
        default:                              wck_d = base;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      acc_q         <= 32'h0000_0000;
      base_q        <= 1'b0;
      div_q         <= 2'b00;
      WCK_OUT       <= 1'b0;
      WCLK_LOCK_OUT <= 1'b0;
      REF_WORD_OUT  <= 1'b0;
    end else if (CE_IN) begin
      acc_q         <= acc_d;
      base_q        <= base;
      div_q         <= div_d;
      WCK_OUT       <= wck_d;
      WCLK_LOCK_OUT <= wlock_d;
      // Drop with the lock flag so the slave flag never outlives the lock
      REF_WORD_OUT  <= sync_d == dai_pkg::SYNC_SLAVE && wlock_d;
    end
  end

  assign status_w = {22'h00_0000, meas_q, cur_rate, sync_q == dai_pkg::SYNC_FALLBACK, slave, wvalid_q, wlock_q};
  assign rdata_d  = !REG_RD_IN                       ? 32'h0000_0000 :
                    REG_ADDR_IN == dai_pkg::REG_CTRL   ? {20'h0_0000, ctrl_q} :
                    REG_ADDR_IN == dai_pkg::REG_STATUS ? status_w :
                    REG_ADDR_IN == dai_pkg::REG_PERIOD ? {19'h0_0000, period_q} : 32'h0000_0000;

  // ****************************************************************
  // Optical channel mapping
  // ****************************************************************
  logic               dbl;
  dai_pkg::dai_chan_t rx_a_d;
  dai_pkg::dai_chan_t rx_b_d;
  dai_pkg::dai_slot_t tx_a_d;
  dai_pkg::dai_slot_t tx_b_d;
  logic               tx_to_a;
  logic               tx_to_b;

  // Double speed spreads each channel over two slots of the frame
  assign dbl = cur_rate >= dai_pkg::RATE_88;

  assign rx_a_d.valid = OPT_A_RX_IN.valid;
  assign rx_a_d.chan  = dbl ? {2'b00, OPT_A_RX_IN.slot[2:1]} : {1'b0, OPT_A_RX_IN.slot};
  assign rx_a_d.phase = dbl ? OPT_A_RX_IN.slot[0] : 1'b0;
  assign rx_a_d.data  = OPT_A_RX_IN.data;

  assign rx_b_d.valid = OPT_B_RX_IN.valid && !b_rx_ser;
  assign rx_b_d.chan  = dbl ? {2'b01, OPT_B_RX_IN.slot[2:1]} : {1'b1, OPT_B_RX_IN.slot};
  assign rx_b_d.phase = dbl ? OPT_B_RX_IN.slot[0] : 1'b0;
  assign rx_b_d.data  = OPT_B_RX_IN.data;

  // Channels 8 and up have no slot at double speed and are dropped
  assign tx_to_a      = TX_IN.valid && (dbl ? TX_IN.chan[3:2] == 2'b00 : !TX_IN.chan[3]);
  assign tx_to_b      = TX_IN.valid && (dbl ? TX_IN.chan[3:2] == 2'b01 : TX_IN.chan[3]) && !b_tx_ser;
  assign tx_a_d.valid = tx_to_a;
  assign tx_a_d.slot  = dbl ? {TX_IN.chan[1:0], TX_IN.phase} : TX_IN.chan[2:0];
  assign tx_a_d.data  = TX_IN.data;
  assign tx_b_d.valid = tx_to_b;
  assign tx_b_d.slot  = dbl ? {TX_IN.chan[1:0], TX_IN.phase} : TX_IN.chan[2:0];
  assign tx_b_d.data  = TX_IN.data;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      RX_A_OUT     <= '0;
      RX_B_OUT     <= '0;
      OPT_A_TX_OUT <= '0;
      OPT_B_TX_OUT <= '0;
    end else if (CE_IN) begin
      RX_A_OUT     <= rx_a_d;
      RX_B_OUT     <= rx_b_d;
      OPT_A_TX_OUT <= tx_a_d;
      OPT_B_TX_OUT <= tx_b_d;
    end
  end

  // ****************************************************************
  // Serial audio receive
  // ****************************************************************
  dai_pkg::dai_sub_t  ser_src;
  dai_pkg::dai_chan_t ser_rx_d;

  assign ser_src        = b_rx_ser ? OPT_B_SER_RX_IN : COAX_RX_IN;
  // Status, copy and emphasis bits are not looked at
  assign ser_rx_d.valid = ser_src.valid;
  assign ser_rx_d.chan  = {3'b000, ser_src.sub};
  assign ser_rx_d.phase = 1'b0;
  assign ser_rx_d.data  = ser_src.data;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      SER_RX_OUT <= '0;
    end else if (CE_IN) begin
      SER_RX_OUT <= ser_rx_d;
    end
  end

  // ****************************************************************
  // Serial audio transmit and header
  // ****************************************************************
  logic [7:0]                      frm_q;
  logic [7:0]                      frm_d;
  logic [dai_pkg::CS_HDR_LEN-1:0] hdr;
  logic [3:0]                      rcode;
  logic [1:0]                      pro_fs;
  logic                            frame_end;
  dai_pkg::dai_sub_t               ser_tx_d;

  always_comb begin
    unique case (cur_rate)
      dai_pkg::RATE_32:  rcode = 4'h3;
      dai_pkg::RATE_44:  rcode = 4'h0;
      dai_pkg::RATE_48:  rcode = 4'h2;
      dai_pkg::RATE_88:  rcode = 4'h8;
      dai_pkg::RATE_96:  rcode = 4'hA;
      dai_pkg::RATE_176: rcode = 4'hC;
      dai_pkg::RATE_192: rcode = 4'hE;
      default:           rcode = 4'h2;
    endcase
  end

  assign pro_fs = cur_rate == dai_pkg::RATE_48 ? 2'b10 :
                  cur_rate == dai_pkg::RATE_44 ? 2'b01 :
                  cur_rate == dai_pkg::RATE_32 ? 2'b11 : 2'b00;

  // Header rebuilt from live settings, so emphasis changes apply mid block
  always_comb begin
    hdr    = '0;
    hdr[0] = pro_fmt;
    hdr[1] = nonaudio;
    if (pro_fmt) begin
      hdr[4:2]   = emph ? 3'b011 : 3'b001;
      hdr[7:6]   = pro_fs;
      hdr[11:8]  = 4'h8;
      hdr[38:35] = rcode;
    end else begin
      hdr[2]     = 1'b1;
      hdr[5:3]   = emph ? 3'b001 : 3'b000;
      hdr[27:24] = rcode;
    end
  end

  assign frame_end = SER_TX_IN.valid && SER_TX_IN.chan[0];
  assign frm_d     = !frame_end ? frm_q :
                     frm_q == 8'(dai_pkg::CS_BLOCK_LEN - 1) ? 8'h00 : frm_q + 8'h01;

  assign ser_tx_d.valid = SER_TX_IN.valid;
  assign ser_tx_d.sub   = SER_TX_IN.chan[0];
  assign ser_tx_d.data  = SER_TX_IN.data;
  assign ser_tx_d.cs    = frm_q < 8'(dai_pkg::CS_HDR_LEN) ? hdr[frm_q[5:0]] : 1'b0;
  assign ser_tx_d.blk   = frm_q == 8'h00 && !SER_TX_IN.chan[0];
  assign ser_tx_d.vbit  = 1'b0;
  assign ser_tx_d.user  = 1'b0;

  always_ff @(posedge CLK_IN or negedge rst_n) begin
    if (!rst_n) begin
      frm_q            <= 8'h00;
      COAX_TX_OUT      <= '0;
      OPT_B_SER_TX_OUT <= '0;
    end else if (CE_IN) begin
      frm_q            <= frm_d;
      COAX_TX_OUT      <= ser_tx_d;
      OPT_B_SER_TX_OUT <= b_tx_ser ? ser_tx_d : '0;
    end
  end

endmodule
